// ---- hdl/siox_pkg.sv ----
// Purpose: shared constants and types of the serial I/O expander core
// Assumes: core clock of 50 MHz, all bus and pin inputs asynchronous
// Notes: port data is sent low byte first on reads
package siox_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int IRQ_VALID_NS = 4000;
    localparam int IV_CYC = IRQ_VALID_NS / CLK_PERIOD_NS;
    // Widths and field positions
    localparam int PORT_W = 16;
    localparam int BYTE_W = 8;
    localparam int RW_BIT = 0;
    localparam int FIFO_DEPTH = 8;
    localparam logic [5:0] ADDR_HI = 6'h10;
    localparam logic [3:0] BIT_ALL = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    // Layout of the synchroniser vector
    localparam int SY_SCL = PORT_W;
    localparam int SY_SDA = PORT_W + 1;
    localparam int SY_STRAP = PORT_W + 2;
    localparam int SY_RISE = PORT_W + 3;
    localparam int SY_FALL = PORT_W + 4;
    localparam int SYNC_W = PORT_W + 5;
    localparam logic [SYNC_W-1:0] SYNC_RST = {SYNC_W{1'b1}};
    // Bus states
    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_TACK = 5'h10
    } siox_state_t;
    // Received byte with frame marker
    typedef struct packed
    {
        logic first;
        logic [BYTE_W-1:0] data;
    } siox_rx_t;
endpackage

// ---- hdl/siox_fifo.sv ----
// Purpose: small synchronous FIFO for received bytes
// Assumes: one clock, valid/ready on both sides
// Notes: in_ready falls only when every slot is taken
`timescale 1ns/100ps
module siox_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    assign in_ready = (count != FULL);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push)
        begin
            next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            next_count = count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage has no reset
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// ---- hdl/siox_core.sv ----
// Purpose: serial I/O expander core: bus slave, port drivers, change interrupt
// Assumes: cfg_input and out_latch come from logic on clk
// Notes: received bytes leave through an 8-word FIFO
//
// Summary of operation
// R01: Input pins have both high and low side drivers off.
// R02: Output pins enable exactly one driver, chosen by the output latch bit.
// R03: Any change on an input pin raises the interrupt after the valid delay.
// R04: Interrupt clears when pins return to captured value or port is read.
// R05: Read clears interrupt at ack or nack after SCL rises.
// R06: After clearing, every later input change is detected again.
// R07: Other slaves' traffic and output pins never touch the interrupt.
// R08: Switching output to input may raise an interrupt on mismatch.
// R09: Interrupt pin is open drain, only pulled low when asserted.
// R10: Reset low holds all state at defaults; master holds minimum width.
// R11: Power-on reset holds until supply rises, re-arms below fall threshold.
// R12: Falling SDA while SCL high starts a transfer.
// R13: Master sends address MSB first, direction in last bit.
// R14: Matching address is acknowledged with SDA low through the ack pulse.
// R15: Address strap stays stable from start to stop.
// R16: SDA changes only while SCL low; otherwise start or stop.
// R17: Rising SDA while SCL high is a stop; device goes idle.
// R18: Bytes are eight bits plus an ack, any number per frame.
// R19: Receiver acknowledges each byte; master acks all but the last. Core nacks a write byte when the FIFO is full.
// R20: Master nack ends a read; device releases SDA for the stop.
// R21: Address is 0100 00, strap bit, then direction bit.
// R22: Transmitter releases SDA before the ack pulse.
// R23: SCL and SDA are synchronised and filtered before detection.
`timescale 1ns/100ps
module siox_core #(
    parameter int FIFO_DEPTH = siox_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Strap and supply monitor
    input wire logic addr_strap,
    input wire logic supply_above_rise,
    input wire logic supply_below_fall,
    // Port configuration
    input wire logic [siox_pkg::PORT_W-1:0] cfg_input,
    input wire logic [siox_pkg::PORT_W-1:0] out_latch,
    // Port pins
    input wire logic [siox_pkg::PORT_W-1:0] port_pins_in,
    output logic [siox_pkg::PORT_W-1:0] port_pins_out,
    output logic [siox_pkg::PORT_W-1:0] port_pins_oe,
    output logic [siox_pkg::PORT_W-1:0] high_side_driver,
    output logic [siox_pkg::PORT_W-1:0] low_side_driver,
    // Interrupt, open drain
    output logic int_n_out,
    output logic int_n_oe,
    // Received bytes
    output siox_pkg::siox_rx_t rx_word,
    output logic rx_valid,
    input wire logic rx_ready
);
    import siox_pkg::*;

    localparam int IV_CW = $clog2(IV_CYC);
    localparam logic [IV_CW-1:0] IV_MAX = IV_CW'(IV_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    // Input synchroniser and filter

    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] filt;
    logic [SYNC_W-1:0] filt_q;
    logic [SYNC_W-1:0] next_filt;
    logic [SYNC_W-1:0] raw_in;

    assign raw_in = {supply_below_fall, supply_above_rise, addr_strap,
                     sda_in, scl_in, port_pins_in};

    // Level taken only when two stages agree
    always_comb
    begin
        next_filt = (~(sync2 ^ sync3) & sync2) | ((sync2 ^ sync3) & filt); // R23
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1 <= SYNC_RST;
            sync2 <= SYNC_RST;
            sync3 <= SYNC_RST;
            filt <= SYNC_RST;
            filt_q <= SYNC_RST;
        end
        else
        begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= next_filt;
            filt_q <= filt;
        end
    end

    logic [PORT_W-1:0] pin_f;
    logic scl_f;
    logic sda_f;
    logic strap_f;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign pin_f = filt[PORT_W-1:0];
    assign scl_f = filt[SY_SCL];
    assign sda_f = filt[SY_SDA];
    assign strap_f = filt[SY_STRAP];
    assign scl_rise = scl_f && !filt_q[SY_SCL];
    assign scl_fall = !scl_f && filt_q[SY_SCL];
    assign start_cond = scl_f && filt_q[SY_SCL] && filt_q[SY_SDA] && !sda_f; // R12 R16
    assign stop_cond = scl_f && filt_q[SY_SCL] && !filt_q[SY_SDA] && sda_f; // R17 R16

    ////////////////////////////////////////////////////////////////////
    // Power-on reset with hysteresis

    logic por_hold;
    logic next_por_hold;

    always_comb
    begin
        next_por_hold = por_hold;
        if (filt[SY_FALL])
        begin
            next_por_hold = 1'b1; // R11
        end
        else if (filt[SY_RISE])
        begin
            next_por_hold = 1'b0; // R11
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            por_hold <= 1'b1; // R10
        end
        else
        begin
            por_hold <= next_por_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus slave

    siox_state_t state;
    siox_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [BYTE_W-1:0] shreg;
    logic [BYTE_W-1:0] next_shreg;
    logic is_addr;
    logic next_is_addr;
    logic rw;
    logic next_rw;
    logic next_sda_oe;
    logic byte_sel;
    logic next_byte_sel;
    logic nack;
    logic next_nack;
    logic first;
    logic next_first;
    logic [PORT_W-1:0] snap;
    logic [PORT_W-1:0] next_snap;
    logic push;
    logic fifo_in_ready;
    logic [BYTE_W-1:0] tx_lo;
    logic [BYTE_W-1:0] tx_hi;
    siox_rx_t push_word;

    assign tx_lo = pin_f[BYTE_W-1:0];
    assign tx_hi = pin_f[PORT_W-1:BYTE_W];
    assign push_word = '{first: first, data: shreg};

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_is_addr = is_addr;
        next_rw = rw;
        next_sda_oe = sda_oe;
        next_byte_sel = byte_sel;
        next_nack = nack;
        next_first = first;
        next_snap = snap;
        push = 1'b0;
        if (por_hold)
        begin
            next_state = ST_IDLE; // R11
            next_cnt = '0;
            next_sda_oe = 1'b0;
            next_snap = pin_f;
        end
        else if (stop_cond)
        begin
            next_state = ST_IDLE; // R17
            next_sda_oe = 1'b0;
        end
        else if (start_cond)
        begin
            next_state = ST_RX; // R12
            next_cnt = '0;
            next_is_addr = 1'b1;
            next_sda_oe = 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    next_sda_oe = 1'b0;
                end
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        next_shreg = {shreg[BYTE_W-2:0], sda_f}; // R13 R18
                        next_cnt = cnt + 4'h1;
                    end
                    else if (scl_fall && cnt == BIT_ALL)
                    begin
                        if (is_addr)
                        begin
                            // Strap is sampled live during the address byte
                            if (shreg[BYTE_W-1:RW_BIT+1] == {ADDR_HI, strap_f}) // R21 R15
                            begin
                                next_state = ST_ACK;
                                next_sda_oe = 1'b1; // R14
                                next_rw = shreg[RW_BIT];
                                next_byte_sel = 1'b0;
                                next_first = 1'b1;
                            end
                            else
                            begin
                                next_state = ST_IDLE; // R07
                            end
                        end
                        else if (fifo_in_ready)
                        begin
                            push = 1'b1;
                            next_first = 1'b0;
                            next_state = ST_ACK;
                            next_sda_oe = 1'b1; // R19
                        end
                        else
                        begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_cnt = '0;
                        next_is_addr = 1'b0;
                        if (rw)
                        begin
                            next_state = ST_TX;
                            next_shreg = tx_lo;
                            next_sda_oe = !tx_lo[BYTE_W-1];
                        end
                        else
                        begin
                            next_state = ST_RX;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt == BIT_LAST)
                        begin
                            next_state = ST_TACK;
                            next_sda_oe = 1'b0; // R22
                        end
                        else
                        begin
                            next_cnt = cnt + 4'h1;
                            next_shreg = {shreg[BYTE_W-2:0], 1'b0};
                            next_sda_oe = !shreg[BYTE_W-2];
                        end
                    end
                end
                ST_TACK:
                begin
                    if (scl_rise)
                    begin
                        next_nack = sda_f;
                        // Read of this port clears its pending change
                        if (byte_sel)
                        begin
                            next_snap[PORT_W-1:BYTE_W] = tx_hi; // R05 R04
                        end
                        else
                        begin
                            next_snap[BYTE_W-1:0] = tx_lo; // R05 R04
                        end
                    end
                    else if (scl_fall)
                    begin
                        if (nack)
                        begin
                            next_state = ST_IDLE; // R20
                            next_sda_oe = 1'b0;
                        end
                        else
                        begin
                            next_state = ST_TX; // R18
                            next_cnt = '0;
                            next_byte_sel = !byte_sel;
                            next_shreg = byte_sel ? tx_lo : tx_hi;
                            next_sda_oe = byte_sel ? !tx_lo[BYTE_W-1] : !tx_hi[BYTE_W-1];
                        end
                    end
                end
                default:
                begin
                    next_state = ST_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_IDLE; // R10
            cnt <= '0;
            shreg <= '0;
            is_addr <= 1'b0;
            rw <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            byte_sel <= 1'b0;
            nack <= 1'b0;
            first <= 1'b0;
            snap <= '0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            is_addr <= next_is_addr;
            rw <= next_rw;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
            byte_sel <= next_byte_sel;
            nack <= next_nack;
            first <= next_first;
            snap <= next_snap;
        end
    end

    siox_fifo #(
        .W($bits(siox_rx_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_word)
    );

    ////////////////////////////////////////////////////////////////////
    // Change interrupt

    logic mismatch;
    logic [IV_CW-1:0] iv_cnt;
    logic [IV_CW-1:0] next_iv_cnt;
    logic next_int_n_oe;

    // Only input pins compared against the captured value
    assign mismatch = |((pin_f ^ snap) & cfg_input); // R03 R06 R07 R08

    always_comb
    begin
        next_iv_cnt = '0;
        next_int_n_oe = 1'b0; // R04
        if (mismatch && !por_hold)
        begin
            next_iv_cnt = (iv_cnt == IV_MAX) ? iv_cnt : iv_cnt + 1'b1;
            next_int_n_oe = int_n_oe || (iv_cnt == IV_MAX); // R03
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            iv_cnt <= '0;
            int_n_oe <= 1'b0;
            int_n_out <= 1'b0;
        end
        else
        begin
            iv_cnt <= next_iv_cnt;
            int_n_oe <= next_int_n_oe; // R09
            int_n_out <= 1'b0; // R09
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port drivers

    logic [PORT_W-1:0] next_high;
    logic [PORT_W-1:0] next_low;

    always_comb
    begin
        next_high = '0; // R01
        next_low = '0; // R01
        if (!por_hold)
        begin
            next_high = ~cfg_input & out_latch; // R02
            next_low = ~cfg_input & ~out_latch; // R02
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            high_side_driver <= '0;
            low_side_driver <= '0;
            port_pins_oe <= '0;
            port_pins_out <= '0;
        end
        else
        begin
            high_side_driver <= next_high;
            low_side_driver <= next_low;
            port_pins_oe <= next_high | next_low;
            port_pins_out <= next_high;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence addr_match;
        state == ST_RX && is_addr && scl_fall && cnt == BIT_ALL && !por_hold
            && !stop_cond && !start_cond
            && shreg[BYTE_W-1:RW_BIT+1] == {ADDR_HI, strap_f};
    endsequence

    sequence ack_rise;
        state == ST_TACK && scl_rise && !por_hold && !stop_cond && !start_cond;
    endsequence

    sequence nack_fall;
        state == ST_TACK && scl_fall && nack && !por_hold && !stop_cond && !start_cond;
    endsequence

    in_drv_off_a: assert property (((high_side_driver | low_side_driver) // R01
        & $past(cfg_input)) == '0)
        else $error("input pin has a driver on");
    one_drv_a: assert property (!por_hold |=> high_side_driver == ($past(out_latch) & ~$past(cfg_input))
        && (high_side_driver & low_side_driver) == '0) // R02
        else $error("output driver does not follow latch");
    irq_delay_a: assert property ($rose(int_n_oe) |-> $past(iv_cnt) == IV_MAX && $past(mismatch)) // R03
        else $error("interrupt raised without full valid delay");
    irq_clear_a: assert property (!mismatch |=> !int_n_oe) // R04
        else $error("interrupt held after pins matched");
    read_clear_a: assert property (ack_rise ##0 !byte_sel |=> snap[BYTE_W-1:0] == $past(tx_lo)) // R05
        else $error("port read did not capture pins");
    out_no_irq_a: assert property (cfg_input == '0 ##1 cfg_input == '0 |-> !int_n_oe) // R07
        else $error("output pins raised interrupt");
    addr_ack_a: assert property (addr_match |=> sda_oe && state == ST_ACK) // R14
        else $error("matching address not acknowledged");
    start_det_a: assert property (start_cond && !por_hold |=> state == ST_RX && is_addr && cnt == '0) // R12
        else $error("start not recognised");
    stop_idle_a: assert property (stop_cond && !por_hold |=> state == ST_IDLE && !sda_oe) // R17
        else $error("stop did not return to idle");
    tx_release_a: assert property (state == ST_TX && scl_fall && cnt == BIT_LAST && !por_hold
        && !stop_cond && !start_cond |=> !sda_oe && state == ST_TACK) // R22
        else $error("data line not released before ack");
    nack_end_a: assert property (nack_fall |=> !sda_oe && state == ST_IDLE) // R20
        else $error("nack did not end the read");
    por_hold_a: assert property (por_hold |=> state == ST_IDLE && !int_n_oe // R11
        && port_pins_oe == '0)
        else $error("power-on hold not applied");
    sda_low_scl_a: assert property ($changed(sda_oe) && !$past(start_cond || stop_cond || por_hold)
        |-> !scl_f) // R16
        else $error("data line moved while clock high");
endmodule

// ---- tb/siox_master.sv ----
// Purpose: bus master model on the serial side of the expander
// Assumes: open-drain bus with pull-ups, sda is the resolved wire
// Notes: half period of 10 core cycles so the input filter keeps up
`timescale 1ns/100ps
module siox_master (
    // Clock
    input wire logic clk,
    // Bus
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic hp();
        repeat (10) @(posedge clk);
    endtask
    task automatic start();
        hp();
        sda_m <= 1'b0;
        hp();
        scl <= 1'b0;
    endtask
    task automatic stop();
        hp();
        sda_m <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        sda_m <= 1'b1;
        hp();
    endtask
    // Data moves only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        hp();
        sda_m <= b;
        hp();
        scl <= 1'b1;
        hp();
        r = sda;
        scl <= 1'b0;
    endtask
    task automatic byte_x(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
        output logic a);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(m_ack, a);
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench of the serial I/O expander core
// Assumes: FIFO depth 2, so a third write byte meets a full buffer
// Notes: link clock slowed to 600 ns, the filter needs 4 cycles a phase
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    import siox_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic strap = 1'b0;
    logic rx_ready = 1'b0;
    logic sup_rise = 1'b1;
    logic sup_fall = 1'b0;
    logic [15:0] cfg = 16'hffff;
    logic [15:0] latch = 16'h0000;
    logic [15:0] pins = 16'h0000;
    logic [15:0] hi_drv, lo_drv;
    logic scl, sda_m, sda, sda_oe, sda_out, int_oe, int_out, rx_valid, a;
    logic [7:0] q;
    siox_rx_t rx_word;
    int err_total = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
    siox_master i_master (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
    siox_core #(.FIFO_DEPTH(2)) i_dut (.clk(clk), .rst_b(rst_b), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(strap),
        .supply_above_rise(sup_rise), .supply_below_fall(sup_fall), .cfg_input(cfg),
        .out_latch(latch), .port_pins_in(pins), .port_pins_out(), .port_pins_oe(),
        .high_side_driver(hi_drv), .low_side_driver(lo_drv), .int_n_out(int_out),
        .int_n_oe(int_oe), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] addr(input logic s, input logic rw);
        return {ADDR_HI, s, rw};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic give_verdict();
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic pop(input logic [8:0] e);
        tick(1);
        `CHK(rx_valid, 1'b1)
        `CHK(rx_word, e)
        rx_ready <= 1'b1;
        tick(1);
        rx_ready <= 1'b0;
        tick(1);
    endtask
    initial
    begin
        #600000;
        err_total++;
        give_verdict();
    end
    initial
    begin
        logic [7:0] d1, d2;
        d1 = $urandom(83855);
        pins <= $urandom;
        tick(4);
        `CHK({sda_oe, int_oe, hi_drv | lo_drv}, 18'h0)
        tick(12);
        rst_b <= 1'b1;
        tick(20);
        `CHK(hi_drv | lo_drv, 16'h0000)
        // All pins outputs: pin changes stay silent
        cfg <= 16'h0000;
        pins <= ~pins;
        tick(250);
        `CHK(int_oe, 1'b0)
        `CHK(lo_drv, 16'hffff)
        pins <= ~pins;
        tick(8);
        repeat (4)
        begin
            cfg <= $urandom;
            latch <= $urandom;
            tick(3);
            `CHK(hi_drv, ~cfg & latch)
            `CHK(lo_drv, ~cfg & ~latch)
        end
        cfg <= 16'h00ff;
        strap <= 1'b1;
        d1 = $urandom;
        d2 = $urandom;
        tick(20);
        // Write that overruns the buffer
        i_master.start();
        i_master.byte_x(addr(1'b1, 1'b0), 1'b1, q, a);
        `CHK(a, 1'b0)
        i_master.byte_x(d1, 1'b1, q, a);
        `CHK(a, 1'b0)
        i_master.byte_x(d2, 1'b1, q, a);
        `CHK(a, 1'b0)
        i_master.byte_x(8'h5a, 1'b1, q, a);
        `CHK(a, 1'b1)
        i_master.stop();
        pop({1'b1, d1});
        pop({1'b0, d2});
        `CHK(rx_valid, 1'b0)
        // Change detection
        pins <= pins ^ 16'h0100;
        tick(250);
        `CHK(int_oe, 1'b0)
        pins <= pins ^ 16'h0004;
        tick(190);
        `CHK(int_oe, 1'b0)
        tick(30);
        `CHK({int_oe, int_out}, 2'b10)
        pins <= pins ^ 16'h0004;
        tick(8);
        `CHK(int_oe, 1'b0)
        pins <= pins ^ 16'h0020;
        tick(220);
        `CHK(int_oe, 1'b1)
        i_master.start();
        i_master.byte_x(addr(1'b0, 1'b0), 1'b1, q, a);
        `CHK(a, 1'b1)
        i_master.stop();
        `CHK(int_oe, 1'b1)
        // Read clears the pending change
        i_master.start();
        i_master.byte_x(addr(1'b1, 1'b1), 1'b1, q, a);
        `CHK(a, 1'b0)
        i_master.byte_x(8'hff, 1'b0, q, a);
        `CHK(q, pins[7:0])
        tick(8);
        `CHK(int_oe, 1'b0)
        i_master.byte_x(8'hff, 1'b1, q, a);
        `CHK(q, pins[15:8])
        tick(12);
        `CHK(sda_oe, 1'b0)
        i_master.stop();
        // Supply dip, hold kept until the rising threshold
        sup_rise <= 1'b0;
        sup_fall <= 1'b1;
        tick(10);
        `CHK(hi_drv | lo_drv, 16'h0000)
        sup_fall <= 1'b0;
        tick(10);
        `CHK(hi_drv | lo_drv, 16'h0000)
        sup_rise <= 1'b1;
        tick(10);
        `CHK(hi_drv, ~cfg & latch)
        give_verdict();
    end
endmodule
